// ---- design/cpa_pkg.sv ----
package cpa_pkg;
  // register map, byte addresses on the wishbone slave
  localparam int WB_AW = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADR_RX_OCTET = 8'h10;

  // control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_FORCE_ALARM = 2;
  localparam int CTRL_FORCE_BLANK = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;

  // status fields
  localparam int STAT_W = 3;
  localparam int STAT_OCTET_ALARM = 0;
  localparam int STAT_RX_ALIGNED = 1;
  localparam int STAT_TX_ALARM = 2;

  // interrupt status and mask fields
  localparam int INT_W = 5;
  localparam int INT_TX_SLIP = 0;
  localparam int INT_RX_SLIP = 1;
  localparam int INT_ALARM_SET = 2;
  localparam int INT_ALARM_CLR = 3;
  localparam int INT_RX_OCTET = 4;
  localparam logic [4:0] INT_MASK_RESET = 5'h00;

  // positions in the synchroniser vector
  localparam int SYNC_W = 16;
  localparam int SI_RX_POS = 0;
  localparam int SI_RX_NEG = 1;
  localparam int SI_BLS = 2;
  localparam int SI_RX_CLK = 3;
  localparam int SI_BLANK = 4;
  localparam int SI_REF_CLK = 5;
  localparam int SI_TX_TSA = 6;
  localparam int SI_TX_TSB = 7;
  localparam int SI_TX_SEL = 8;
  localparam int SI_ALARM_IN = 9;
  localparam int SI_LINE_CLK = 10;
  localparam int SI_PCM_IN = 11;
  localparam int SI_TX_CLK = 12;
  localparam int SI_RX_TSA = 13;
  localparam int SI_RX_TSB = 14;
  localparam int SI_RX_SEL = 15;
  // active-low line inputs and supervision idle high
  localparam logic [15:0] SYNC_RESET = 16'h0007;

  // timing
  localparam int OCTET_BITS = 8;
  localparam int REF_CLOCK_KHZ = 2048;
  localparam int LINE_RATE_KBPS = 64;
  localparam int OCTET_PERIOD_US = 125;
  localparam int TICKS_PER_BIT = REF_CLOCK_KHZ / LINE_RATE_KBPS;
  localparam logic [4:0] PH_LAST = 5'(TICKS_PER_BIT - 1);
  localparam logic [4:0] PH_POL = 5'(TICKS_PER_BIT / 8);
  localparam logic [4:0] PH_BIT = 5'(3 * TICKS_PER_BIT / 8);
  localparam logic [4:0] PH_RESYNC = 5'(3 * TICKS_PER_BIT / 4);
  localparam int ALARM_OCTETS = 2;
  localparam logic [9:0] ALARM_TICKS = 10'(ALARM_OCTETS * OCTET_PERIOD_US * REF_CLOCK_KHZ / 1000);
  localparam logic [6:0] LOS_TICKS = 7'(2 * TICKS_PER_BIT);

  // receive alignment state
  typedef enum logic [1:0] {
    RX_NOSIG = 2'b00,
    RX_HUNT = 2'b01,
    RX_ALIGNED = 2'b10
  } cpa_rx_state_t;

  // codirectional quarter pattern: one is mark mark space space, zero is mark space mark space
  function automatic logic cpa_quarter_mark(input logic bit_val, input logic [1:0] quarter);
    cpa_quarter_mark = bit_val ? ~quarter[1] : ~quarter[0];
  endfunction : cpa_quarter_mark
endpackage : cpa_pkg

// ---- design/cpa_sync.sv ----
`timescale 1ns/10ps
module cpa_sync #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] meta;
  logic [W-1:0] last;

  // two flops; the first is looked at by nothing but the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

  // edge finder works on the settled copy only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last <= RESET_VAL;
    end else begin
      last <= sync_out;
    end
  end

  assign rise_out = sync_out & ~last;
endmodule : cpa_sync

// ---- design/cpa_adapter.sv ----
`timescale 1ns/10ps
// Overview of operation
// - capture eight bits from the chosen pcm slot, send them as continuous 64k code
// - decode received 64k code, recover bit timing, replay octets in chosen receive slot
// - on clock slips repeat or drop whole octets, never single bits
// - one octet of buffering gives 125us of drift tolerance per path
// - alarm send request high stops violation insertion on the transmit line
// - octet alarm output high while received violations are missing
// - supervision low with receive alarm blanks the received pcm output
// - blank input high forces received pcm output to all ones
// - transmit select high picks strobe a, low picks strobe b
// - receive select high picks strobe a, low picks strobe b
// - received line inputs are active low, one per mark polarity
// - transmit line outputs are active low, one per mark polarity
// - received pcm shifts out on the system receive bus clock
// - clock recovery runs from the separate reference clock
// - transmit line code timed by the 256k line clock, one quarter per cycle
// - transmit pcm sampled on transmit bus clock with the chosen strobe
module cpa_adapter
  import cpa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic rx_pos_n,
  input wire logic rx_neg_n,
  input wire logic byte_lock_supervise_n,
  input wire logic rx_bus_clock,
  input wire logic output_blank,
  input wire logic recovery_ref_clock,
  input wire logic tx_slot_strobe_a,
  input wire logic tx_slot_strobe_b,
  input wire logic tx_slot_select,
  input wire logic alarm_send_request,
  input wire logic tx_line_clock,
  input wire logic tx_pcm_serial_in,
  input wire logic tx_bus_clock,
  input wire logic rx_slot_strobe_a,
  input wire logic rx_slot_strobe_b,
  input wire logic rx_slot_select,
  output logic tx_pos_n,
  output logic tx_neg_n,
  output logic rx_pcm_serial_out,
  output logic octet_alarm
);
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] pins_s;
  logic [SYNC_W-1:0] pins_rise;
  logic [CTRL_W-1:0] ctrl;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] w1c;
  logic [31:0] rd_data;
  logic wb_req;
  logic wb_wr;
  // transmit side
  logic tx_strobe;
  logic tx_alarm_active;
  logic [7:0] tx_in_sh;
  logic [2:0] tx_in_cnt;
  logic [7:0] tx_hold;
  logic tx_new;
  logic tx_store;
  logic tx_load;
  logic tx_slip;
  logic [1:0] enc_q;
  logic [2:0] enc_idx;
  logic [7:0] enc_sh;
  logic [7:0] enc_last;
  logic enc_pol;
  logic enc_mark;
  logic [7:0] next_tx_word;
  // receive side
  cpa_rx_state_t rx_state;
  logic mark_p;
  logic mark_n;
  logic prev_p;
  logic prev_n;
  logic mark_start;
  logic resync;
  logic ref_tick;
  logic [4:0] phase;
  logic blk_pol;
  logic last_pol;
  logic rx_bit;
  logic rx_viol;
  logic bit_strobe;
  logic [7:0] rx_sh;
  logic [7:0] rx_hold;
  logic rx_new;
  logic rx_store;
  logic [6:0] los_cnt;
  logic [9:0] viol_timer;
  logic alarm_set;
  logic alarm_clr;
  logic rx_strobe;
  logic rx_load;
  logic rx_slip;
  logic [2:0] out_cnt;
  logic [7:0] out_sh;
  logic [7:0] out_last;
  logic [7:0] next_rx_word;
  logic rx_blank;

  // every pin from outside except sys_clk, the wishbone bus and reset, other clocks included, is resampled on sys_clk
  assign pins = {rx_slot_select, rx_slot_strobe_b, rx_slot_strobe_a, tx_bus_clock, tx_pcm_serial_in,
                 tx_line_clock, alarm_send_request, tx_slot_select, tx_slot_strobe_b, tx_slot_strobe_a,
                 recovery_ref_clock, output_blank, rx_bus_clock, byte_lock_supervise_n, rx_neg_n, rx_pos_n};

  cpa_sync #(
    .W(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(pins),
    .sync_out(pins_s),
    .rise_out(pins_rise)
  );

  // wishbone classic slave, one wait state, ack drops the cycle after
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL: rd_data[CTRL_W-1:0] = ctrl;
      ADR_STATUS: rd_data[STAT_W-1:0] = {tx_alarm_active, rx_state == RX_ALIGNED, octet_alarm};
      ADR_INT_STATUS: rd_data[INT_W-1:0] = int_status;
      ADR_INT_MASK: rd_data[INT_W-1:0] = int_mask;
      ADR_RX_OCTET: rd_data[7:0] = rx_hold;
      default: rd_data = 32'h0000_0000; // unmapped reads zero, still acked
    endcase
  end

  // ack and read data leave registered together
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // writes land on the edge where the master sees ack
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      int_mask <= INT_MASK_RESET;
    end else if (wb_wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl <= wb_dat_i[CTRL_W-1:0];
      end
      if (wb_adr_i == ADR_INT_MASK) begin
        int_mask <= wb_dat_i[INT_W-1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle survives
  assign w1c = (wb_wr && wb_adr_i == ADR_INT_STATUS) ? wb_dat_i[INT_W-1:0] : '0;
  assign events = {rx_store & (rx_state == RX_ALIGNED), alarm_clr, alarm_set, rx_slip, tx_slip};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= '0;
      irq <= 1'b0;
    end else begin
      int_status <= (int_status & ~w1c) | events;
      irq <= |(int_status & int_mask);
    end
  end

  // ---- transmit capture from the pcm bus
  assign tx_strobe = pins_s[SI_TX_SEL] ? pins_s[SI_TX_TSA] : pins_s[SI_TX_TSB];
  assign tx_store = pins_rise[SI_TX_CLK] & tx_strobe & (tx_in_cnt == 3'(OCTET_BITS - 1));

  // shift on bus clock rise while the slot is open; a short slot restarts the count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_in_sh <= 8'h00;
      tx_in_cnt <= 3'h0;
    end else if (pins_rise[SI_TX_CLK]) begin
      if (tx_strobe) begin
        tx_in_sh <= {tx_in_sh[6:0], pins_s[SI_PCM_IN]};
        tx_in_cnt <= tx_in_cnt + 3'h1;
      end else begin
        tx_in_cnt <= 3'h0;
      end
    end
  end

  // one-octet hold buffer; overwriting an unsent octet drops it whole
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold <= 8'hff;
      tx_new <= 1'b0;
    end else begin
      if (tx_store) begin
        tx_hold <= {tx_in_sh[6:0], pins_s[SI_PCM_IN]};
        tx_new <= 1'b1;
      end else if (tx_load) begin
        tx_new <= 1'b0;
      end
    end
  end

  // ---- transmit encoder, one quarter per line clock rise
  assign tx_alarm_active = pins_s[SI_ALARM_IN] | ctrl[CTRL_FORCE_ALARM];
  assign tx_load = pins_rise[SI_LINE_CLK] & (enc_q == 2'h3) & (enc_idx == 3'(OCTET_BITS - 1));
  assign next_tx_word = tx_new ? tx_hold : enc_last;
  assign tx_slip = (tx_load & ~tx_new) | (tx_store & tx_new & ~tx_load);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enc_q <= 2'h3;
      enc_idx <= 3'h7;
      enc_sh <= 8'hff;
      enc_last <= 8'hff;
      enc_pol <= 1'b0;
    end else if (pins_rise[SI_LINE_CLK]) begin
      enc_q <= enc_q + 2'h1;
      if (enc_q == 2'h3) begin
        if (tx_load) begin
          enc_sh <= next_tx_word; // stale octet is repeated when none arrived
          enc_last <= next_tx_word;
          enc_idx <= 3'h0;
        end else begin
          enc_sh <= {enc_sh[6:0], 1'b0};
          enc_idx <= enc_idx + 3'h1;
        end
        // last block of the octet keeps the polarity unless alarm is being sent
        if (enc_idx == 3'(OCTET_BITS - 2) && !tx_alarm_active) begin
          enc_pol <= enc_pol;
        end else begin
          enc_pol <= ~enc_pol;
        end
      end
    end
  end

  assign enc_mark = cpa_quarter_mark(enc_sh[7], enc_q) & ctrl[CTRL_TX_EN];

  // active-low line drive, idle high when disabled
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_pos_n <= 1'b1;
      tx_neg_n <= 1'b1;
    end else begin
      tx_pos_n <= ~(enc_mark & enc_pol);
      tx_neg_n <= ~(enc_mark & ~enc_pol);
    end
  end

  // ---- receive clock recovery
  assign mark_p = ~pins_s[SI_RX_POS];
  assign mark_n = ~pins_s[SI_RX_NEG];
  assign mark_start = (mark_p & ~prev_p) | (mark_n & ~prev_n);
  assign ref_tick = pins_rise[SI_REF_CLK];
  // a zero's second mark keeps polarity; late or flipped marks restart the phase
  assign resync = mark_start & (rx_state == RX_NOSIG || phase >= PH_RESYNC || mark_p != blk_pol);
  assign bit_strobe = ref_tick & (phase == PH_BIT) & (rx_state != RX_NOSIG);
  assign rx_bit = mark_p | mark_n;
  assign rx_viol = blk_pol == last_pol;
  assign rx_store = bit_strobe & rx_viol & ctrl[CTRL_RX_EN];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_p <= 1'b0;
      prev_n <= 1'b0;
      phase <= 5'h00;
      los_cnt <= 7'h00;
    end else begin
      prev_p <= mark_p;
      prev_n <= mark_n;
      if (resync) begin
        phase <= 5'h00;
      end else if (ref_tick) begin
        phase <= (phase == PH_LAST) ? 5'h00 : phase + 5'h01;
      end
      if (rx_bit) begin
        los_cnt <= 7'h00;
      end else if (ref_tick && los_cnt != LOS_TICKS) begin
        los_cnt <= los_cnt + 7'h01;
      end
    end
  end

  // block polarity early in the first quarter, bit value in the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      blk_pol <= 1'b0;
      last_pol <= 1'b1;
      rx_sh <= 8'h00;
    end else begin
      if (ref_tick && phase == PH_POL) begin
        blk_pol <= mark_p;
      end
      if (bit_strobe) begin
        last_pol <= blk_pol;
        rx_sh <= {rx_sh[6:0], rx_bit};
      end
    end
  end

  // alignment: a violation closes an octet; losing them drops back to hunting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= RX_NOSIG;
    end else if (!ctrl[CTRL_RX_EN] || los_cnt == LOS_TICKS) begin
      rx_state <= RX_NOSIG;
    end else begin
      case (rx_state)
        RX_NOSIG: begin
          if (resync) begin
            rx_state <= RX_HUNT;
          end
        end
        RX_HUNT: begin
          if (rx_store) begin
            rx_state <= RX_ALIGNED;
          end
        end
        RX_ALIGNED: begin
          if (alarm_set) begin
            rx_state <= RX_HUNT;
          end
        end
        default: rx_state <= RX_NOSIG;
      endcase
    end
  end

  // octet alarm: no violation for two octet periods of reference time
  assign alarm_set = ~octet_alarm & (viol_timer == ALARM_TICKS);
  assign alarm_clr = octet_alarm & rx_store;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      viol_timer <= ALARM_TICKS;
      octet_alarm <= 1'b1;
    end else begin
      if (rx_store) begin
        viol_timer <= 10'h000;
      end else if (ref_tick && viol_timer != ALARM_TICKS) begin
        viol_timer <= viol_timer + 10'h001;
      end
      if (rx_store) begin
        octet_alarm <= 1'b0;
      end else if (viol_timer == ALARM_TICKS) begin
        octet_alarm <= 1'b1;
      end
    end
  end

  // one-octet receive hold; the first octet after hunting is partial and dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_hold <= 8'hff;
      rx_new <= 1'b0;
    end else begin
      if (rx_store && rx_state == RX_ALIGNED) begin
        rx_hold <= {rx_sh[6:0], rx_bit};
        rx_new <= 1'b1;
      end else if (rx_load) begin
        rx_new <= 1'b0;
      end
    end
  end

  // ---- receive slot output
  assign rx_strobe = pins_s[SI_RX_SEL] ? pins_s[SI_RX_TSA] : pins_s[SI_RX_TSB];
  assign rx_load = pins_rise[SI_RX_CLK] & rx_strobe & (out_cnt == 3'h0);
  assign next_rx_word = rx_new ? rx_hold : out_last;
  assign rx_slip = (rx_load & ~rx_new) | (rx_store & (rx_state == RX_ALIGNED) & rx_new & ~rx_load);
  assign rx_blank = pins_s[SI_BLANK] | ctrl[CTRL_FORCE_BLANK] | (~pins_s[SI_BLS] & octet_alarm);

  // bit shifts out per bus clock rise; outside the slot the pin idles high
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_cnt <= 3'h0;
      out_sh <= 8'hff;
      out_last <= 8'hff;
      rx_pcm_serial_out <= 1'b1;
    end else if (pins_rise[SI_RX_CLK]) begin
      if (rx_strobe) begin
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == 3'h0) begin
          out_last <= next_rx_word; // no fresh octet means a whole repeat
          out_sh <= {next_rx_word[6:0], 1'b1};
          rx_pcm_serial_out <= next_rx_word[7] | rx_blank;
        end else begin
          out_sh <= {out_sh[6:0], 1'b1};
          rx_pcm_serial_out <= out_sh[7] | rx_blank;
        end
      end else begin
        out_cnt <= 3'h0;
        rx_pcm_serial_out <= 1'b1;
      end
    end else if (rx_blank) begin
      rx_pcm_serial_out <= 1'b1;
    end
  end
endmodule : cpa_adapter

// ---- sim/cpa_adapter_chk.sv ----
`timescale 1ns/10ps
// watches adapter pins only; loose window on line timing
module cpa_adapter_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic byte_lock_supervise_n,
  input wire logic output_blank,
  input wire logic tx_line_clock,
  input wire logic rx_slot_strobe_a,
  input wire logic rx_slot_strobe_b,
  input wire logic tx_pos_n,
  input wire logic tx_neg_n,
  input wire logic rx_pcm_serial_out,
  input wire logic octet_alarm
);
  logic lc_q;
  logic [2:0] lc_age;
  logic [4:0] idle_age;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // cycles since a line clock rise and since a slot, saturating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lc_q <= 1'b0;
      lc_age <= 3'h7;
      idle_age <= 5'h00;
    end else begin
      lc_q <= tx_line_clock;
      lc_age <= (tx_line_clock && !lc_q) ? 3'h0 : lc_age + {2'h0, lc_age != 3'h7};
      idle_age <= (rx_slot_strobe_a || rx_slot_strobe_b) ? 5'h00 : idle_age + {4'h0, idle_age != 5'h1f};
    end
  end
  sequence req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  chk_ack_one_wait: assert property (req_taken |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  chk_tx_one_mark: assert property (!(!tx_pos_n && !tx_neg_n))
    else $error("both line outputs marking");
  chk_tx_paced: assert property ($changed({tx_pos_n, tx_neg_n}) |-> lc_age inside {[3'h2:3'h6]})
    else $error("line output moved off the line clock");
  chk_blank_ones: assert property (output_blank [*6] |-> rx_pcm_serial_out)
    else $error("blank did not force ones");
  chk_bls_blank: assert property ((!byte_lock_supervise_n && octet_alarm) [*6] |-> rx_pcm_serial_out)
    else $error("supervision did not blank");
  chk_rx_idle_high: assert property (idle_age == 5'h1f |-> rx_pcm_serial_out)
    else $error("pcm output not idle high");
  chk_reset_outs: assert property ($rose(nrst) |-> tx_pos_n && tx_neg_n && octet_alarm && rx_pcm_serial_out)
    else $error("outputs wrong after reset");
endmodule : cpa_adapter_chk

bind cpa_adapter cpa_adapter_chk u_chk (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .byte_lock_supervise_n, .output_blank, .tx_line_clock, .rx_slot_strobe_a, .rx_slot_strobe_b,
  .tx_pos_n, .tx_neg_n, .rx_pcm_serial_out, .octet_alarm);

// ---- sim/cpa_line_model.sv ----
`timescale 1ns/10ps
// line interface stand-in: repeats one octet in four-quarter code
module cpa_line_model (
  input wire logic clk,
  input wire logic en,
  input wire logic viol_en,
  input wire logic [7:0] octet,
  output logic pos_n,
  output logic neg_n
);
  logic [4:0] tick = 5'h00;
  logic [2:0] bitn = 3'h0;
  logic pol = 1'b0;
  logic cur, mark;
  initial begin
    pos_n = 1'b1;
    neg_n = 1'b1;
  end
  assign cur = octet[3'h7 - bitn]; // msb first
  // marks in quarters 0 and 1 for a one, 0 and 2 for a zero
  assign mark = tick[4:3] == 2'h0 || (tick[4:3] == 2'h1 && cur) || (tick[4:3] == 2'h2 && !cur);
  // blocks alternate; an octet's last block keeps polarity
  always @(posedge clk) begin
    tick <= tick + 5'h01;
    if (tick == 5'h1f) begin
      bitn <= bitn + 3'h1;
      pol <= (bitn == 3'h6 && viol_en) ? pol : !pol;
    end
  end
  // active-low marks, both high when silent
  always @(posedge clk) begin
    pos_n <= !(en && mark && pol);
    neg_n <= !(en && mark && !pol);
  end
endmodule : cpa_line_model

// ---- sim/tb_top.sv ----
`timescale 1ns/10ps
module tb_top import cpa_pkg::*;
;
  logic sys_clk = 1'b0, nrst = 1'b0, tx_line_clock = 1'b0, recovery_ref_clock = 1'b0;
  logic tx_bus_clock = 1'b0, rx_bus_clock = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, x;
  logic wb_ack_o, irq, rx_pos_n, rx_neg_n, tx_pos_n, tx_neg_n, rx_pcm_serial_out, octet_alarm;
  logic byte_lock_supervise_n = 1'b1, output_blank = 1'b0, alarm_send_request = 1'b0;
  logic tx_slot_strobe_a = 1'b0, tx_slot_strobe_b = 1'b0, tx_slot_select = 1'b1, tx_pcm_serial_in = 1'b1;
  logic rx_slot_strobe_a = 1'b0, rx_slot_strobe_b = 1'b0, rx_slot_select = 1'b1;
  logic m_viol = 1'b1, m_en = 1'b0, cap = 1'b0, lc_q = 1'b0;
  logic [7:0] oct;
  logic [2:0] lc_age = 3'h0;
  logic [1:0] sym[$];
  int num_errors = 0, tests_run = 0, nv, k;
  always #5 sys_clk = ~sys_clk;
  always #40 tx_line_clock = ~tx_line_clock; // 80 ns link clock
  always #41 recovery_ref_clock = ~recovery_ref_clock;
  always #37 tx_bus_clock = ~tx_bus_clock;
  always #39 rx_bus_clock = ~rx_bus_clock;
  cpa_adapter dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq, .rx_pos_n, .rx_neg_n, .byte_lock_supervise_n, .rx_bus_clock,
    .output_blank, .recovery_ref_clock, .tx_slot_strobe_a, .tx_slot_strobe_b, .tx_slot_select,
    .alarm_send_request, .tx_line_clock, .tx_pcm_serial_in, .tx_bus_clock, .rx_slot_strobe_a,
    .rx_slot_strobe_b, .rx_slot_select, .tx_pos_n, .tx_neg_n, .rx_pcm_serial_out, .octet_alarm);
  cpa_line_model u_line (.clk(recovery_ref_clock), .en(m_en), .viol_en(m_viol), .octet(8'h96),
    .pos_n(rx_pos_n), .neg_n(rx_neg_n));
  // one line symbol per quarter, once settled
  always @(posedge sys_clk) begin
    lc_q <= tx_line_clock;
    lc_age <= (tx_line_clock && !lc_q) ? 3'h0 : lc_age + 3'h1;
    if (cap && lc_age == 3'h6) sym.push_back({~tx_pos_n, ~tx_neg_n});
  end
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= wd;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge sys_clk);
    chk({31'h0, n == 20}, 32'h0, "bus hang");
    if (n == 20) close_out();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer
  task automatic rdc(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, adr, 32'h0, r);
    chk(r & mask, exp, "reg read");
  endtask : rdc
  // a slot of eight bus clocks on the chosen strobe, msb first
  task automatic tx_slot(input logic sel, input logic use_a, input logic [7:0] d);
    tx_slot_select <= sel;
    @(negedge tx_bus_clock);
    @(posedge sys_clk);
    tx_slot_strobe_a <= use_a;
    tx_slot_strobe_b <= !use_a;
    for (int i = 7; i >= 0; i--) begin
      tx_pcm_serial_in <= d[i];
      @(negedge tx_bus_clock);
      @(posedge sys_clk);
    end
    tx_slot_strobe_a <= 1'b0;
    tx_slot_strobe_b <= 1'b0;
  endtask : tx_slot
  // align on quarter 0 mark, quarter 3 space; octet ends at last violation
  task automatic tx_grab(output logic [7:0] o8, output int nvio);
    int o, v, j;
    logic [22:0] pol, bits;
    sym.delete();
    cap = 1'b1;
    for (j = 0; j < 4000 && sym.size() < 96; j++) @(posedge sys_clk);
    cap = 1'b0;
    if (sym.size() < 96) num_errors++;
    if (sym.size() < 96) close_out();
    o = -1;
    for (int t = 0; t < 4; t++) begin
      j = 0;
      while (j < 23 && sym[t + 4 * j] != 2'b00 && sym[t + 4 * j + 3] == 2'b00) j++;
      if (j == 23) o = t;
    end
    nvio = 0;
    v = 0;
    o8 = 8'hxx;
    if (o < 0) return;
    for (j = 0; j < 23; j++) begin
      pol[j] = sym[o + 4 * j][1];
      bits[j] = sym[o + 4 * j + 1] != 2'b00;
      if (j > 0 && pol[j] == pol[j - 1]) begin
        nvio++;
        v = j;
      end
    end
    if (v >= 7) for (j = 0; j < 8; j++) o8[7 - j] = bits[v - 7 + j];
  endtask : tx_grab
  task automatic rx_slot(input logic sel, input logic use_a, input logic [7:0] exp);
    rx_slot_select <= sel;
    @(negedge rx_bus_clock);
    @(posedge sys_clk);
    rx_slot_strobe_a <= use_a;
    rx_slot_strobe_b <= !use_a;
    for (int i = 7; i >= 0; i--) begin
      @(posedge rx_bus_clock);
      repeat (6) @(posedge sys_clk);
      chk({31'h0, rx_pcm_serial_out}, {31'h0, exp[i]}, "pcm bit");
    end
    rx_slot_strobe_a <= 1'b0;
    rx_slot_strobe_b <= 1'b0;
  endtask : rx_slot
  task automatic wait_alarm(input logic v);
    int n;
    for (n = 0; n < 12000 && octet_alarm !== v; n++) @(posedge sys_clk);
    chk({31'h0, octet_alarm}, {31'h0, v}, "alarm pin");
    if (n == 12000) close_out();
    repeat (4) @(posedge sys_clk);
  endtask : wait_alarm
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk({28'h0, tx_pos_n, tx_neg_n, rx_pcm_serial_out, octet_alarm}, 32'hf, "reset pins");
    rdc(ADR_CTRL, 32'hffffffff, 32'(CTRL_RESET));
    rdc(ADR_INT_MASK, 32'hffffffff, 32'h0);
    rdc(ADR_RX_OCTET, 32'hffffffff, 32'hff);
    xfer(1'b1, 8'h20, 32'hff, x);
    rdc(8'h20, 32'hffffffff, 32'h0);
    $display("reset and registers done");
    tx_slot(1'b1, 1'b1, 8'ha5);
    tx_grab(oct, nv);
    chk({24'h0, oct}, 32'ha5, "tx octet a");
    tx_slot(1'b1, 1'b0, 8'h3c);
    tx_grab(oct, nv);
    chk({24'h0, oct}, 32'ha5, "tx wrong strobe");
    tx_slot(1'b0, 1'b0, 8'h3c);
    tx_grab(oct, nv);
    chk({24'h0, oct}, 32'h3c, "tx octet b");
    alarm_send_request <= 1'b1;
    repeat (400) @(posedge sys_clk);
    tx_grab(oct, nv);
    chk(32'(nv), 32'h0, "tx violations");
    rdc(ADR_STATUS, 32'h1 << STAT_TX_ALARM, 32'h1 << STAT_TX_ALARM);
    alarm_send_request <= 1'b0;
    $display("transmit done");
    m_en <= 1'b1;
    x = 32'h0;
    for (k = 0; k < 60 && x !== 32'h96; k++) begin
      repeat (400) @(posedge sys_clk);
      xfer(1'b0, ADR_RX_OCTET, 32'h0, x);
    end
    chk(x, 32'h96, "rx octet");
    wait_alarm(1'b0);
    rx_slot(1'b1, 1'b1, 8'h96);
    rx_slot(1'b0, 1'b1, 8'hff);
    rx_slot(1'b0, 1'b0, 8'h96);
    output_blank <= 1'b1;
    rx_slot(1'b0, 1'b0, 8'hff);
    output_blank <= 1'b0;
    $display("receive done");
    xfer(1'b1, ADR_INT_STATUS, 32'h1f, x);
    xfer(1'b1, ADR_INT_MASK, 32'h1 << INT_ALARM_SET, x);
    chk({31'h0, irq}, 32'h0, "irq idle");
    m_viol <= 1'b0;
    wait_alarm(1'b1);
    chk({31'h0, irq}, 32'h1, "irq set");
    xfer(1'b1, ADR_INT_MASK, 32'h0, x);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    xfer(1'b1, ADR_INT_MASK, 32'h1 << INT_ALARM_SET, x);
    rdc(ADR_INT_STATUS, 32'h1 << INT_ALARM_SET, 32'h1 << INT_ALARM_SET);
    xfer(1'b1, ADR_INT_STATUS, 32'h1 << INT_ALARM_SET, x);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rx_slot(1'b0, 1'b0, 8'h96);
    byte_lock_supervise_n <= 1'b0;
    rx_slot(1'b0, 1'b0, 8'hff);
    byte_lock_supervise_n <= 1'b1;
    m_viol <= 1'b1;
    wait_alarm(1'b0);
    $display("alarm and interrupt done");
    close_out();
  end
endmodule : tb_top
